/* File: logic/parallel_port_addr_status.sv */
// Purpose: parallel port address, pin routing, strobe timing, slave buffers
// Assumes: APB slave, zero wait states; host pins asynchronous
// Notes: strobes active high; polarity handled outside
// Functional notes
// - write hold is one to four periods
// - read hold is zero to three periods
// - strobe wait zero forces setup and hold
// - chip select bit never auto-steps
// - csf 10: bit 14 is chip select
// - csf 00/01: bit 14 is address
// - address bits 10:0 held, gaps read zero
// - high route enable gives pad 14
// - pin enables route pads 10 to 0
// - pads 1:0 address or latch strobes
// - all-full only when every input full
// - overflow on write to full, sticky
// - slot full until software reads it
// - all-empty only when every output empty
// - underflow on read of empty, sticky
// - slot empty until software writes it
// - buffer status only in slave modes
// - csf picks chip select or address
// - multiplex selection picks three layouts
// - step mode increments or decrements address
// - mode codes: two slave, two master
`timescale 1ns/1ps
`default_nettype none
`include "pp_cfg.svh"
module parallel_port_addr_status (
  input wire logic core_clk, // core clock
  input wire logic reset, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [14:0] port_address_pins, // address pads
  output logic [14:0] port_address_oe_n, // pad enables, low drives
  output logic [7:0] port_data_out, // data pads out
  output logic port_data_oe_n, // data enable, low drives
  input wire logic [7:0] port_data_in, // data pads in
  output logic read_strobe, // master read strobe
  output logic write_strobe, // master write strobe
  input wire logic host_cs, // host chip select
  input wire logic host_rd, // host read strobe
  input wire logic host_wr, // host write strobe
  input wire logic [1:0] host_addr // host slot address
);
  // registers
  logic [14:0] mode_q; // mode and timing
  logic [10:0] addr_q; // destination address
  logic addr_hi; // bit 14: address or chip select
  logic [10:0] pin_en; // address pin enables
  logic high_pin_route_enable; // pad 14 enable
  logic port_on; // port enable
  logic [1:0] multiplex_selection; // address/data layout
  logic [1:0] chip_select_function; // pad 14 use
  logic [7:0] mdata_q; // master data
  logic [7:0] in_buf [4]; // input bytes from host
  logic [7:0] out_buf [4]; // output bytes to host
  logic [3:0] input_slot_full; // per-slot full
  logic [3:0] output_slot_empty; // per-slot empty
  logic input_overflow; // sticky overflow
  logic output_underflow; // sticky underflow
  // field views
  wire [1:0] address_step_mode = mode_q[12:11];
  wire [1:0] port_mode = mode_q[9:8];
  wire [1:0] setup_wait_field = mode_q[7:6];
  wire [3:0] strobe_wait_field = mode_q[5:2];
  wire [1:0] hold_wait_field = mode_q[1:0];
  // modes 00/01 slave, 10/11 master
  wire slave_mode = !port_mode[1];
  wire enhanced_slave = port_mode == 2'h1;
  wire master_mode = port_mode[1] & port_on;
  wire cs_mode = chip_select_function == `PP_CSF_CHIPSEL;
  // apb decode
  wire apb_setup = psel & !penable;
  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite;
  wire apb_rd = apb_access & !pwrite;
  wire word_ok = paddr[1:0] == 2'h0;
  wire hit_mode = word_ok & (paddr == `PP_OFF_MODE);
  wire hit_addr = word_ok & (paddr == `PP_OFF_ADDR);
  wire hit_pinen = word_ok & (paddr == `PP_OFF_PINEN);
  wire hit_stat = word_ok & (paddr == `PP_OFF_STAT);
  wire hit_ctrl = word_ok & (paddr == `PP_OFF_CTRL);
  wire hit_mdata = word_ok & (paddr == `PP_OFF_MDATA);
  wire hit_in = word_ok & (paddr[7:4] == `PP_OFF_INBUF);
  wire hit_out = word_ok & (paddr[7:4] == `PP_OFF_OUTBUF);
  wire [1:0] bus_slot = paddr[3:2];
  wire mapped = hit_mode | hit_addr | hit_pinen | hit_stat | hit_ctrl | hit_mdata | hit_in | hit_out;
  // master cycle engine
  logic busy; // cycle running
  logic in_setup; // address phase
  logic first_setup; // first address cycle
  logic in_strobe; // strobe phase
  logic cyc_done; // cycle end pulse
  logic cyc_rd; // cycle is a read
  // writes start a cycle; reading data starts the next read
  wire start_wr = master_mode & !busy & apb_wr & hit_mdata;
  wire start_rd = master_mode & !busy & apb_rd & hit_mdata;
  strobe_timer #(.CW(5)) strobe_timer_i (
    .core_clk(core_clk),
    .reset(reset),
    .start(start_wr | start_rd),
    .is_read(start_rd),
    .setup_code(setup_wait_field),
    .strobe_code(strobe_wait_field),
    .hold_code(hold_wait_field),
    .busy(busy),
    .in_setup(in_setup),
    .first_setup(first_setup),
    .in_strobe(in_strobe),
    .done(cyc_done),
    .rd_q(cyc_rd)
  );
  // host pin synchroniser: cs, rd, wr, addr, data
  logic [12:0] host_lvl; // filtered host pins
  pin_sync #(.W(13)) pin_sync_i (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in({host_cs, host_rd, host_wr, host_addr, port_data_in}),
    .level(host_lvl)
  );
  wire h_cs = host_lvl[12];
  wire h_rd = host_lvl[11];
  wire h_wr = host_lvl[10];
  wire [7:0] h_data = host_lvl[7:0];
  logic h_rd_prev; // host read last cycle
  logic h_wr_prev; // host write last cycle
  logic h_cs_prev; // host select last cycle
  // legacy slave uses slot 0 only
  wire [1:0] h_slot = enhanced_slave ? host_lvl[9:8] : 2'h0;
  // host events only count in slave modes
  wire host_on = slave_mode & port_on;
  wire host_rd_evt = host_on & h_rd & !h_rd_prev & h_cs;
  wire host_wr_evt = host_on & !h_wr & h_wr_prev & h_cs_prev;
  // edge history of host strobes
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      h_rd_prev <= 1'b0;
      h_wr_prev <= 1'b0;
      h_cs_prev <= 1'b0;
    end
    else
    begin
      h_rd_prev <= h_rd;
      h_wr_prev <= h_wr;
      h_cs_prev <= h_cs;
    end
  end
  // per-slot buffers and flags
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_slot
      wire hw_wr = host_wr_evt & (h_slot == 2'(gi));
      wire hw_rd = host_rd_evt & (h_slot == 2'(gi));
      wire sw_rd = apb_rd & hit_in & (bus_slot == 2'(gi));
      wire sw_wr = apb_wr & hit_out & (bus_slot == 2'(gi));
      // host write fills a slot; full slot keeps old byte
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          in_buf[gi] <= 8'h00;
          out_buf[gi] <= 8'h00;
          input_slot_full[gi] <= 1'b0;
          output_slot_empty[gi] <= 1'b1;
        end
        else
        begin
          if (hw_wr && !input_slot_full[gi])
            in_buf[gi] <= h_data;
          // set by host write wins over software read
          input_slot_full[gi] <= hw_wr | (input_slot_full[gi] & !sw_rd);
          if (sw_wr)
            out_buf[gi] <= pwdata[7:0];
          // set by host read wins over software write
          output_slot_empty[gi] <= hw_rd | (output_slot_empty[gi] & !sw_wr);
        end
      end
    end
  endgenerate
  // summaries from slot flags
  wire all_inputs_full = &input_slot_full;
  wire all_outputs_empty = &output_slot_empty;
  wire ovf_evt = host_wr_evt & input_slot_full[h_slot];
  wire unf_evt = host_rd_evt & output_slot_empty[h_slot];
  wire stat_wr = apb_wr & hit_stat;
  // sticky errors; hardware set wins over clear by 0
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      input_overflow <= 1'b0;
      output_underflow <= 1'b0;
    end
    else
    begin
      input_overflow <= ovf_evt | (input_overflow & !(stat_wr & !pwdata[`PP_BIT_HI]));
      output_underflow <= unf_evt | (output_underflow & !(stat_wr & !pwdata[`PP_BIT_UFLOW]));
    end
  end
  // address stepping after each master cycle
  wire [9:0] step_full = {addr_hi, addr_q[10:2]};
  wire [9:0] step_next = (address_step_mode == `PP_STEP_INC) ? step_full + 10'h001 : step_full - 10'h001;
  wire stepping = cyc_done & (address_step_mode == `PP_STEP_INC | address_step_mode == `PP_STEP_DEC);
  // chip select bit keeps its value while stepping
  wire next_addr_hi = cs_mode ? addr_hi : step_next[9];
  wire [8:0] next_mid = cs_mode ? 9'(step_next[8:0]) : step_next[8:0];
  // configuration registers; software write wins over stepping
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= 15'h0000;
      addr_q <= 11'h000;
      addr_hi <= 1'b0;
      pin_en <= 11'h000;
      high_pin_route_enable <= 1'b0;
      port_on <= 1'b0;
      multiplex_selection <= 2'h0;
      chip_select_function <= 2'h0;
      mdata_q <= 8'h00;
    end
    else
    begin
      if (apb_wr && hit_mode)
        mode_q <= pwdata[14:0] & 15'(`PP_MASK_MODE);
      if (apb_wr && hit_addr)
      begin
        addr_q <= pwdata[10:0];
        addr_hi <= pwdata[`PP_BIT_HI];
      end
      else if (stepping)
      begin
        addr_q[10:2] <= next_mid;
        addr_hi <= next_addr_hi;
      end
      if (apb_wr && hit_pinen)
      begin
        pin_en <= pwdata[10:0];
        high_pin_route_enable <= pwdata[`PP_BIT_HI];
      end
      if (apb_wr && hit_ctrl)
      begin
        port_on <= pwdata[`PP_BIT_ON];
        multiplex_selection <= pwdata[12:11];
        chip_select_function <= pwdata[7:6];
      end
      if (start_wr)
        mdata_q <= pwdata[7:0];
      else if (cyc_done && cyc_rd)
        mdata_q <= h_data;
    end
  end
  // status word: zero outside slave modes
  wire [31:0] stat_word = slave_mode ? {16'h0000, all_inputs_full, input_overflow, 2'h0, input_slot_full,
    all_outputs_empty, output_underflow, 2'h0, output_slot_empty} : 32'h0000_0000;
  wire [31:0] mode_word = {16'h0000, busy, mode_q};
  // bits 13:11 and 31:15 read zero
  wire [31:0] addr_word = {17'h0_0000, addr_hi, 3'h0, addr_q};
  wire [31:0] pinen_word = {17'h0_0000, high_pin_route_enable, 3'h0, pin_en};
  wire [31:0] ctrl_word = {16'h0000, port_on, 2'h0, multiplex_selection, 3'h0, chip_select_function, 6'h00};
  wire [31:0] rd_word =
    hit_mode ? mode_word :
    hit_addr ? addr_word :
    hit_pinen ? pinen_word :
    hit_stat ? stat_word :
    hit_ctrl ? ctrl_word :
    hit_mdata ? {24'h00_0000, mdata_q} :
    hit_in ? {24'h00_0000, in_buf[bus_slot]} :
    hit_out ? {24'h00_0000, out_buf[bus_slot]} : 32'h0000_0000;
  // read data captured in setup, stable through access
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      prdata <= 32'h0000_0000;
    else if (apb_setup)
      prdata <= rd_word;
  end
  assign pready = 1'b1;
  assign pslverr = apb_access & !mapped;
  // pad values: bit 14 drives address or chip select
  wire [1:0] low_pads = (multiplex_selection == `PP_MUX_SEPARATE) ? addr_q[1:0] :
    {first_setup & (multiplex_selection == `PP_MUX_FULL16), in_setup & !(first_setup &
    (multiplex_selection == `PP_MUX_FULL16))};
  wire [14:0] next_pads = {addr_hi, 3'h0, addr_q[10:2], low_pads};
  wire drive = master_mode;
  wire [14:0] next_oe_n = {!(drive & high_pin_route_enable), 3'h7, ~(pin_en & {11{drive}})};
  // data pads: address in setup when multiplexed, else data
  wire mux_on = multiplex_selection != `PP_MUX_SEPARATE;
  wire [7:0] hi_byte = {addr_hi, 4'h0, addr_q[10:8]};
  wire [7:0] m_data = (in_setup & mux_on) ?
    ((first_setup & multiplex_selection == `PP_MUX_FULL16) ? hi_byte : addr_q[7:0]) : mdata_q;
  wire m_drive = busy & (!cyc_rd | (in_setup & mux_on));
  wire s_drive = host_on & h_rd & h_cs;
  // pad and strobe flops
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      port_address_pins <= 15'h0000;
      port_address_oe_n <= 15'h7FFF;
      port_data_out <= 8'h00;
      port_data_oe_n <= 1'b1;
      read_strobe <= 1'b0;
      write_strobe <= 1'b0;
    end
    else
    begin
      port_address_pins <= next_pads;
      port_address_oe_n <= next_oe_n;
      if (host_rd_evt)
        port_data_out <= out_buf[h_slot];
      else if (master_mode)
        port_data_out <= m_data;
      port_data_oe_n <= !(master_mode ? m_drive : s_drive);
      read_strobe <= in_strobe & cyc_rd;
      write_strobe <= in_strobe & !cyc_rd;
    end
  end
  all_full_a: assert property (@(posedge core_clk) disable iff (reset)
    apb_setup && hit_stat && slave_mode |=> prdata[`PP_BIT_IFULL] == $past(&input_slot_full))
    else $error("all-inputs-full read mismatch");
  all_empty_a: assert property (@(posedge core_clk) disable iff (reset)
    apb_setup && hit_stat && slave_mode |=> prdata[`PP_BIT_OEMPTY] == $past(&output_slot_empty))
    else $error("all-outputs-empty read mismatch");
  overflow_set_a: assert property (@(posedge core_clk) disable iff (reset)
    ovf_evt |=> input_overflow ##1 (input_overflow || $past(stat_wr)))
    else $error("overflow not held");
  underflow_set_a: assert property (@(posedge core_clk) disable iff (reset)
    unf_evt |=> output_underflow)
    else $error("underflow not set");
  cs_frozen_a: assert property (@(posedge core_clk) disable iff (reset)
    cyc_done && cs_mode && !(apb_wr && hit_addr) |=> addr_hi == $past(addr_hi))
    else $error("chip select bit stepped");
  addr_step_a: assert property (@(posedge core_clk) disable iff (reset)
    cyc_done && address_step_mode == `PP_STEP_INC && !(apb_wr && hit_addr) |=>
    addr_q[10:2] == 9'($past(addr_q[10:2]) + 9'h001))
    else $error("address increment wrong");
  pad14_off_a: assert property (@(posedge core_clk) disable iff (reset)
    !high_pin_route_enable |=> port_address_oe_n[14])
    else $error("pad 14 driven while routed off");
  slot_read_a: assert property (@(posedge core_clk) disable iff (reset)
    apb_rd && hit_in && !host_wr_evt |=> !input_slot_full[$past(bus_slot)])
    else $error("input slot not cleared by read");
  overflow_c: cover property (@(posedge core_clk) disable iff (reset) ovf_evt);
  host_read_c: cover property (@(posedge core_clk) disable iff (reset) host_rd_evt && !unf_evt);
  step_c: cover property (@(posedge core_clk) disable iff (reset) stepping);
endmodule : parallel_port_addr_status
`default_nettype wire

/* File: inc/pp_cfg.svh */
// Purpose: offsets, fields, codes and timing of the port
// Assumes: 8-bit APB byte address, 32-bit data
// Notes: definitions only
`ifndef PP_CFG_SVH
`define PP_CFG_SVH
// register byte offsets
`define PP_OFF_MODE 8'h00
`define PP_OFF_ADDR 8'h04
`define PP_OFF_PINEN 8'h08
`define PP_OFF_STAT 8'h0C
`define PP_OFF_CTRL 8'h10
`define PP_OFF_MDATA 8'h14
`define PP_OFF_INBUF 4'h2
`define PP_OFF_OUTBUF 4'h3
// writable bit masks
`define PP_MASK_MODE 32'h0000_7BFF
`define PP_MASK_ADDR 32'h0000_47FF
`define PP_MASK_PINEN 32'h0000_47FF
`define PP_MASK_CTRL 32'h0000_98C0
// field positions
`define PP_BIT_BUSY 15
`define PP_BIT_HI 14
`define PP_BIT_ON 15
`define PP_BIT_IFULL 15
`define PP_BIT_OEMPTY 7
`define PP_BIT_UFLOW 6
// field codes
`define PP_CSF_CHIPSEL 2'h2
`define PP_STEP_INC 2'h1
`define PP_STEP_DEC 2'h2
`define PP_MUX_SEPARATE 2'h0
`define PP_MUX_FULL16 2'h2
`define PP_WAIT_FORCED 4'h0
// reset values
`define PP_RST_SLOT_EMPTY 4'hF
// timing: one peripheral clock period, ps
`define PP_CLK_PS 5000
`define PP_TPB_PS 5000
`define PP_TPB_CYC ((`PP_TPB_PS + `PP_CLK_PS - 1) / `PP_CLK_PS)
`endif

/* File: inc/pp_pkg.sv */
// Purpose: shared types of the parallel port
// Assumes: nothing
// Notes: constants live in pp_cfg.svh
package pp_pkg;
  // master strobe sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} timer_state_e;
endpackage : pp_pkg

/* File: logic/pin_sync.sv */
// Purpose: three-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk
// Notes: a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 13
) (
  input wire logic core_clk, // core clock
  input wire logic reset, // async reset, high
  input wire logic [W-1:0] pin_in, // raw pins
  output logic [W-1:0] level // filtered level
);
  logic [W-1:0] s1; // first stage, read by s2 only
  logic [W-1:0] s2; // second stage
  logic [W-1:0] s3; // third stage
  // shift chain; level follows only agreeing bits
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      level <= (s2 & s3) | (level & (s2 ^ s3));
    end
  end
endmodule : pin_sync
`default_nettype wire

/* File: logic/strobe_timer.sv */
// Purpose: setup, strobe and hold sequencing of a master cycle
// Assumes: wait codes stable while idle; latched at start
// Notes: lengths in peripheral clock periods
`timescale 1ns/1ps
`default_nettype none
`include "pp_cfg.svh"
module strobe_timer #(
  parameter int CW = 5
) (
  input wire logic core_clk, // core clock
  input wire logic reset, // async reset, high
  input wire logic start, // begin a cycle, pulse
  input wire logic is_read, // cycle direction
  input wire logic [1:0] setup_code, // setup wait field
  input wire logic [3:0] strobe_code, // strobe wait field
  input wire logic [1:0] hold_code, // hold wait field
  output logic busy, // cycle running
  output logic in_setup, // address phase
  output logic first_setup, // first setup cycle
  output logic in_strobe, // strobe phase
  output logic done, // cycle end pulse
  output logic rd_q // latched direction
);
  pp_pkg::timer_state_e state; // sequencer state
  logic [CW-1:0] cnt; // cycles left in phase
  logic [CW-1:0] strobe_len; // latched strobe length
  logic [CW-1:0] hold_len; // latched hold length
  logic first; // first setup cycle flag
  wire forced = strobe_code == `PP_WAIT_FORCED;
  // setup: one period when forced
  wire [CW-1:0] setup_units = forced ? CW'(1) : CW'(setup_code) + CW'(1);
  // write hold 1..4, read hold 0..3
  wire [CW-1:0] hold_units = forced ? CW'(!is_read) : CW'(hold_code) + CW'(!is_read);
  wire [CW-1:0] setup_len = CW'(setup_units * `PP_TPB_CYC);
  wire [CW-1:0] next_strobe = CW'((CW'(strobe_code) + CW'(1)) * `PP_TPB_CYC);
  wire [CW-1:0] next_hold = CW'(hold_units * `PP_TPB_CYC);
  assign busy = state != pp_pkg::ST_IDLE;
  assign in_setup = state == pp_pkg::ST_SETUP;
  assign first_setup = in_setup & first;
  assign in_strobe = state == pp_pkg::ST_STROBE;
  // phase sequencing, lengths fixed at start
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= pp_pkg::ST_IDLE;
      cnt <= '0;
      strobe_len <= '0;
      hold_len <= '0;
      rd_q <= 1'b0;
      done <= 1'b0;
      first <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      first <= 1'b0;
      unique case (state)
        pp_pkg::ST_IDLE:
        begin
          if (start)
          begin
            state <= pp_pkg::ST_SETUP;
            cnt <= setup_len - CW'(1);
            strobe_len <= next_strobe;
            hold_len <= next_hold;
            rd_q <= is_read;
            first <= 1'b1;
          end
        end
        pp_pkg::ST_SETUP:
        begin
          cnt <= cnt - CW'(1);
          if (cnt == '0)
          begin
            state <= pp_pkg::ST_STROBE;
            cnt <= strobe_len - CW'(1);
          end
        end
        pp_pkg::ST_STROBE:
        begin
          cnt <= cnt - CW'(1);
          if (cnt == '0)
          begin
            // read hold may be zero: end at once
            state <= (hold_len == '0) ? pp_pkg::ST_IDLE : pp_pkg::ST_HOLD;
            done <= hold_len == '0;
            cnt <= hold_len - CW'(1);
          end
        end
        pp_pkg::ST_HOLD:
        begin
          cnt <= cnt - CW'(1);
          if (cnt == '0)
          begin
            state <= pp_pkg::ST_IDLE;
            done <= 1'b1;
          end
        end
      endcase
    end
  end
  logic [CW-1:0] hold_seen; // helper: hold cycles observed
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      hold_seen <= '0;
    else if (in_strobe)
      hold_seen <= '0;
    else if (state == pp_pkg::ST_HOLD)
      hold_seen <= hold_seen + CW'(1);
  end
  write_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    start && !busy && !is_read && !forced |=> hold_len == CW'((CW'(hold_code) + CW'(1)) * `PP_TPB_CYC))
    else $error("write hold length wrong");
  read_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    start && !busy && is_read && !forced |=> hold_len == CW'(CW'(hold_code) * `PP_TPB_CYC))
    else $error("read hold length wrong");
  hold_count_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(done) |-> hold_seen == hold_len)
    else $error("hold phase length mismatch");
  forced_read_a: assert property (@(posedge core_clk) disable iff (reset)
    start && !busy && is_read && forced |=> in_setup ##1 in_strobe ##1 done)
    else $error("forced read timing wrong");
  forced_write_a: assert property (@(posedge core_clk) disable iff (reset)
    start && !busy && !is_read && forced |=> in_setup ##1 in_strobe ##1 !done ##1 done)
    else $error("forced write timing wrong");
  write_cycle_c: cover property (@(posedge core_clk) disable iff (reset) done && !rd_q);
  read_cycle_c: cover property (@(posedge core_clk) disable iff (reset) done && rd_q);
endmodule : strobe_timer
`default_nettype wire

/* File: verification/host_model.sv */
// Purpose: external host driving slave byte transfers
// Assumes: strobes held well past the pin filter
// Notes: a released data line shows the inverse byte
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk, // core clock
  input wire logic [7:0] port_data_out, // byte from port
  output logic host_cs, // chip select
  output logic host_rd, // read strobe
  output logic host_wr, // write strobe
  output logic [1:0] host_addr, // slot address
  output logic [7:0] port_data_in, // byte to port
  output logic [7:0] seen // byte taken on a read
);
  initial {host_cs, host_rd, host_wr, host_addr, port_data_in, seen} = '0;
  // one host cycle; six edges per phase beat the filter
  task automatic xfer(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {host_cs, host_addr, port_data_in, host_wr, host_rd} <= {1'b1, a, d, wr, !wr};
    repeat (6) @(posedge core_clk);
    seen = port_data_out; // taken while read strobe held
    {host_wr, host_rd} <= 2'b00; // write commits on falling strobe
    repeat (6) @(posedge core_clk);
    {host_cs, port_data_in} <= {1'b0, ~d}; // stale data not left on line
    repeat (6) @(posedge core_clk);
  endtask : xfer
endmodule : host_model
`default_nettype wire

/* File: verification/parallel_port_addr_status_test.sv */
// Purpose: self-checking bench of the parallel port
// Assumes: apb slave with one-cycle access
// Notes: host side played by host_model
`timescale 1ns/1ps
`default_nettype none
`include "pp_cfg.svh"
module parallel_port_addr_status_test;
  logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0; // apb master
  logic [7:0] paddr = '0, port_data_in, port_data_out, seen, dat[4]; // bytes
  logic [31:0] pwdata = '0, prdata, q, r; // words
  logic pready, pslverr, e, read_strobe, write_strobe, port_data_oe_n; // flags
  logic host_cs, host_rd, host_wr; // host pins
  logic [1:0] host_addr; // host slot
  logic [14:0] port_address_pins, port_address_oe_n; // pads
  int n_fail = 0, compares = 0, seed = 87, n, s; // counters
  always #2.5 core_clk = ~core_clk;
  parallel_port_addr_status parallel_port_addr_status_i (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_address_pins(port_address_pins), .port_address_oe_n(port_address_oe_n),
    .port_data_out(port_data_out), .port_data_oe_n(port_data_oe_n), .port_data_in(port_data_in),
    .read_strobe(read_strobe), .write_strobe(write_strobe), .host_cs(host_cs), .host_rd(host_rd),
    .host_wr(host_wr), .host_addr(host_addr));
  host_model host_model_i (.core_clk(core_clk), .port_data_out(port_data_out), .host_cs(host_cs),
    .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr), .port_data_in(port_data_in), .seen(seen));
  task automatic give_verdict;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, x, g);
    end
  endtask : chk
  // address after one increment, bit 14 held as chip select
  function automatic logic [31:0] exp_step(input logic [31:0] a);
    return {17'h0_0000, a[14], 3'h0, 9'(a[10:2] + 9'h001), a[1:0]};
  endfunction : exp_step
  // one apb transfer; waits on pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1 && n < 50);
    chk("pready", 1, pready);
    if (pready !== 1)
      give_verdict;
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  initial
  begin
    repeat (10) @(posedge core_clk);
    reset <= 0;
    apb(0, `PP_OFF_STAT, 0);
    chk("stat", 32'h0000_008F, q);
    r = $random(seed);
    apb(1, `PP_OFF_ADDR, r);
    apb(0, `PP_OFF_ADDR, 0);
    chk("addr", r & 32'h0000_47FF, q);
    apb(1, `PP_OFF_CTRL, 32'h0000_8000); // port on before host traffic
    apb(1, `PP_OFF_MODE, 32'h0000_0100); // enhanced slave, host picks slot
    for (int i = 0; i < 4; i++)
    begin
      dat[i] = $random(seed);
      host_model_i.xfer(1, i[1:0], dat[i]);
    end
    host_model_i.xfer(1, 2'd2, 8'h5A); // write into a full slot
    apb(0, `PP_OFF_STAT, 0);
    chk("stat", 32'h0000_CF8F, q);
    for (int i = 0; i < 4; i++)
    begin
      apb(0, {`PP_OFF_INBUF, i[1:0], 2'b00}, 0);
      chk("inbuf", {24'h0, dat[i]}, q);
    end
    apb(0, `PP_OFF_STAT, 0);
    chk("stat", 32'h0000_408F, q);
    apb(1, `PP_OFF_STAT, 0);
    host_model_i.xfer(0, 2'd3, 8'h00); // read of an empty slot
    apb(0, `PP_OFF_STAT, 0);
    chk("stat", 32'h0000_00CF, q);
    apb(1, {`PP_OFF_OUTBUF, 4'h4}, {24'h0, r[15:8]});
    apb(0, `PP_OFF_STAT, 0);
    chk("stat", 32'h0000_004D, q);
    host_model_i.xfer(0, 2'd1, 8'h00);
    chk("host", {24'h0, r[15:8]}, {24'h0, seen});
    apb(0, `PP_OFF_STAT, 0);
    chk("stat", 32'h0000_00CF, q);
    apb(1, `PP_OFF_PINEN, r);
    // forced write, forced read, then both with a random strobe code
    for (int j = 0; j < 4; j++)
    begin
      s = j[1] ? ($random(seed) & 15) : 0;
      apb(1, `PP_OFF_MODE, 32'h0000_0200 | (s << 2));
      apb(!j[0], `PP_OFF_MDATA, r);
      for (int k = 0; k < 40 && (j[0] ? read_strobe : write_strobe) !== 1; k++) @(posedge core_clk);
      chk("data oe_n", j[0], port_data_oe_n);
      for (n = 0; (j[0] ? read_strobe : write_strobe) === 1 && n < 40; n++) @(posedge core_clk);
      chk("strobe", s + 1, n);
      repeat (20) @(posedge core_clk);
    end
    apb(1, `PP_OFF_CTRL, 32'h0000_8080); // bit 14 acts as chip select
    apb(1, `PP_OFF_MODE, 32'h0000_0A07); // master, increment, strobe 2, hold 4
    apb(1, `PP_OFF_MDATA, r);
    repeat (12) @(posedge core_clk);
    apb(0, `PP_OFF_ADDR, 0);
    chk("step", exp_step(r), q);
    chk("pads", exp_step(r), {17'h0_0000, port_address_pins});
    chk("pad oe_n", {17'h0_0000, ~r[14], 3'h7, ~r[10:0]}, {17'h0_0000, port_address_oe_n});
    apb(0, `PP_OFF_STAT, 0);
    chk("stat", 0, q);
    apb(0, 8'hFC, 0);
    chk("slverr", 1, e);
    give_verdict;
  end
endmodule : parallel_port_addr_status_test
`default_nettype wire
